// file: host_image_buffer.sv
// Host side byte sink with optional random stalls
`default_nettype none
module host_image_buffer (
   input wire logic clk_i,
   input wire logic slow_i,
   output logic ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial ready_o = 1'b0;
   // Changes away from the sampling edge
   always @(negedge clk_i) ready_o <= slow_i ? 1'($urandom % 2) : 1'b1;
endmodule
`default_nettype wire

// file: mono_pixel_packer.sv
// Monochrome pixel packer: sample stream in, layout-formatted byte stream out
`default_nettype none
module mono_pixel_packer
   import mono_pixel_packer_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire layout_t layout_i,
   input wire logic pix_valid_i,
   input wire pix_beat_t pix_i,
   output logic pix_ready_o,
   output logic byte_valid_o,
   output byte_beat_t byte_o,
   input wire logic byte_ready_i,
   output logic frame_active_o,
   output logic odd_frame_err_o
);

   typedef enum logic {st_accept, st_emit} state_t;

   state_t state;
   layout_t frame_layout;
   logic odd_phase;
   logic [PIX_W-1:0] held_pix;
   byte_group_t pend;
   logic [CNT_W-1:0] idx;
   logic [CNT_W-1:0] cnt;
   logic last_pend;

   wire logic take;
   wire logic send;
   wire layout_t cur_layout;
   wire logic cur_odd;
   wire byte_group_t map_bytes;
   wire logic [CNT_W-1:0] map_count;
   wire logic [CNT_W-1:0] step_idx;
   wire logic final_byte;
   wire logic short_frame;
   wire logic take_accept;
   wire logic group_take;
   wire logic emit_send;
   wire logic group_done;
   wire logic group_step;
   wire logic first_last;
   wire logic step_last;

   state_t next_state;
   logic next_pix_ready;
   logic next_byte_valid;
   logic [CNT_W-1:0] next_idx;
   wire layout_t next_frame_layout;
   wire logic next_odd_phase;
   wire logic [PIX_W-1:0] next_held_pix;
   wire logic next_frame_active;
   wire logic next_odd_err;
   wire byte_group_t next_pend;
   wire logic [CNT_W-1:0] next_cnt;
   wire logic next_last_pend;
   wire logic [BYTE_W-1:0] next_byte_data;
   wire logic next_byte_last;

   // Frame-closing flag: the frame ends and byte pos of n is the final one
   function automatic logic closes_frame(input logic frame_end, input logic [CNT_W-1:0] pos,
      input logic [CNT_W-1:0] n);
      closes_frame = frame_end && (pos == n);
   endfunction

   assign take = pix_valid_i && pix_ready_o;
   assign send = byte_valid_o && byte_ready_i;
   // A frame start picks up the selection live; later pixels keep it
   assign cur_layout = pix_i.first ? layout_i : frame_layout;
   assign cur_odd = pix_i.first ? 1'b0 : odd_phase;
   assign step_idx = CNT_W'(idx + IDX_SECOND);
   assign final_byte = (idx == cnt);
   // Even final pixel in a paired layout cannot complete its group
   assign short_frame = pix_i.last && is_paired(cur_layout) && !cur_odd;

   pair_byte_mapper mapper (
      .layout_i(cur_layout),
      .odd_i(cur_odd),
      .pixel_i(pix_i.data),
      .held_i(held_pix),
      .bytes_o(map_bytes),
      .count_o(map_count)
   );

   // Events: a pixel taken, a group loaded, a byte handed on
   assign take_accept = (state == st_accept) && take;
   assign group_take = take_accept && (map_count != CNT_NONE);
   assign emit_send = (state == st_emit) && send;
   assign group_done = emit_send && final_byte;
   assign group_step = emit_send && !final_byte;
   assign first_last = closes_frame(pix_i.last, IDX_SECOND, map_count);
   assign step_last = closes_frame(last_pend, step_idx, cnt);

   // Frame tracking follows every accepted pixel
   assign next_frame_layout = take_accept ? cur_layout : frame_layout;
   assign next_odd_phase = take_accept ? !cur_odd : odd_phase;
   assign next_held_pix = take_accept ? pix_i.data : held_pix;
   assign next_frame_active = take_accept ? !pix_i.last : frame_active_o;
   // Set beats the frame-start clear
   assign next_odd_err = (take_accept && short_frame) ? 1'b1 :
                         (take_accept && pix_i.first) ? 1'b0 : odd_frame_err_o;

   // Group contents load only with a producing pixel
   assign next_pend = group_take ? map_bytes : pend;
   assign next_cnt = group_take ? map_count : cnt;
   assign next_last_pend = group_take ? pix_i.last : last_pend;
   assign next_byte_data = group_take ? map_bytes[0] :
                           group_step ? pend[idx[1:0]] : byte_o.data;
   assign next_byte_last = group_take ? first_last :
                           group_step ? step_last :
                           group_done ? 1'b0 : byte_o.last;

   // Two states: take pixels, or drain a group
   always_comb begin
      next_state = state;
      case (state)
         st_accept: begin
            if (group_take) begin
               next_state = st_emit;
            end
         end
         st_emit: begin
            if (group_done) begin
               next_state = st_accept;
            end
         end
         default: begin
            next_state = st_accept;
         end
      endcase
   end

   // Stall the source while a group drains
   always_comb begin
      next_pix_ready = pix_ready_o;
      next_byte_valid = byte_valid_o;
      case (state)
         st_accept: begin
            if (group_take) begin
               next_pix_ready = 1'b0;
               next_byte_valid = 1'b1;
            end
         end
         st_emit: begin
            if (group_done) begin
               next_pix_ready = 1'b1;
               next_byte_valid = 1'b0;
            end
         end
         default: begin
            next_pix_ready = 1'b1;
            next_byte_valid = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_idx = idx;
      case (state)
         st_accept: begin
            if (group_take) begin
               next_idx = IDX_SECOND;
            end
         end
         st_emit: begin
            if (group_step) begin
               next_idx = step_idx;
            end
         end
         default: begin
            next_idx = idx;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= st_accept;
      end else begin
         state <= next_state;
      end
   end

   // Ready out of reset so the first pixel can enter
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pix_ready_o <= 1'b1;
      end else begin
         pix_ready_o <= next_pix_ready;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         byte_valid_o <= 1'b0;
      end else begin
         byte_valid_o <= next_byte_valid;
      end
   end

   // Layout held for the rest of the frame
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         frame_layout <= LAYOUT_RESET;
      end else begin
         frame_layout <= next_frame_layout;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         odd_phase <= 1'b0;
      end else begin
         odd_phase <= next_odd_phase;
      end
   end

   // Even pixel waits here for its partner
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         held_pix <= PIX_RESET;
      end else begin
         held_pix <= next_held_pix;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         frame_active_o <= 1'b0;
      end else begin
         frame_active_o <= next_frame_active;
      end
   end

   // Sticky until the next frame start
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         odd_frame_err_o <= 1'b0;
      end else begin
         odd_frame_err_o <= next_odd_err;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pend <= '0;
      end else begin
         pend <= next_pend;
      end
   end

   // Position of the next byte to present
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         idx <= CNT_NONE;
      end else begin
         idx <= next_idx;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt <= CNT_NONE;
      end else begin
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         last_pend <= 1'b0;
      end else begin
         last_pend <= next_last_pend;
      end
   end

   // Byte output stays put while the host stalls
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         byte_o <= BYTE_BEAT_RESET;
      end else begin
         byte_o <= '{last: next_byte_last, data: next_byte_data};
      end
   end

endmodule
`default_nettype wire

// file: mono_pixel_packer_monitor.sv
// Concurrent checks on the ports of the pixel packer
`default_nettype none
module mono_pixel_packer_monitor
   import mono_pixel_packer_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire layout_t layout_i,
   input wire logic pix_valid_i,
   input wire pix_beat_t pix_i,
   input wire logic pix_ready_o,
   input wire logic byte_valid_o,
   input wire byte_beat_t byte_o,
   input wire logic byte_ready_i,
   input wire logic frame_active_o,
   input wire logic odd_frame_err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic tk = pix_valid_i && pix_ready_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_first(layout_t l);
      tk && pix_i.first && layout_i == l;
   endsequence
   // Pair only counted when odd pixel follows at once
   sequence s_pair(layout_t l);
      s_first(l) ##1 tk;
   endsequence
   AST_HOLD: assert property (byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_o))
      else $error("byte moved while stalled");
   AST_LAST: assert property (byte_valid_o && byte_ready_i && byte_o.last |=> !byte_valid_o)
      else $error("valid after final byte");
   AST_BUSY: assert property (byte_valid_o |-> !pix_ready_o)
      else $error("pixel ready during group");
   AST_M8: assert property (s_first(layout_mono8) |=> byte_valid_o && byte_o.data == $past(pix_i.data[11:4]))
      else $error("mono8 byte wrong");
   AST_M16: assert property (s_first(layout_mono16) |=> byte_valid_o && byte_o.data == $past(pix_i.data[7:0]))
      else $error("mono16 low byte wrong");
   AST_M16H: assert property (s_first(layout_mono16) ##1 byte_ready_i |=>
      byte_valid_o && byte_o.data == {4'h0, $past(pix_i.data[11:8], 2)})
      else $error("mono16 high byte wrong");
   AST_EVEN: assert property (tk && pix_i.first && is_paired(layout_i) |=> !byte_valid_o)
      else $error("even pixel produced bytes");
   AST_P12: assert property (s_pair(layout_packed12) |=> byte_valid_o && byte_o.data == $past(pix_i.data[11:4], 2))
      else $error("packed first byte wrong");
   AST_CHR: assert property (s_pair(chroma_emulation_layout) |=> byte_valid_o && byte_o.data == 8'h00)
      else $error("chroma byte not zero");
endmodule
`default_nettype wire

// file: mono_pixel_packer_pkg.sv
// Shared types, constants and helpers of the monochrome pixel packer
`default_nettype none
package mono_pixel_packer_pkg;

   localparam int PIX_W = 12;
   localparam int BYTE_W = 8;
   localparam int MAX_BYTES = 4;
   localparam int CNT_W = 3;
   localparam int LUMA_LSB = 4;

   // Bytes produced per accepted pixel, by layout and pair phase
   localparam logic [CNT_W-1:0] CNT_NONE = 3'h0;
   localparam logic [CNT_W-1:0] CNT_MONO8 = 3'h1;
   localparam logic [CNT_W-1:0] CNT_MONO16 = 3'h2;
   localparam logic [CNT_W-1:0] CNT_PACKED12 = 3'h3;
   localparam logic [CNT_W-1:0] CNT_CHROMA = 3'h4;
   localparam logic [CNT_W-1:0] IDX_SECOND = 3'h1;

   localparam logic [BYTE_W-1:0] CHROMA_ZERO = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   localparam logic [PIX_W-1:0] PIX_RESET = 12'h000;

   typedef enum logic [1:0] {
      layout_mono8,
      layout_mono16,
      layout_packed12,
      chroma_emulation_layout
   } layout_t;

   localparam layout_t LAYOUT_RESET = layout_mono8;

   typedef struct packed {
      logic first;
      logic last;
      logic [PIX_W-1:0] data;
   } pix_beat_t;

   typedef struct packed {
      logic last;
      logic [BYTE_W-1:0] data;
   } byte_beat_t;

   localparam byte_beat_t BYTE_BEAT_RESET = '{last: 1'b0, data: 8'h00};

   typedef logic [MAX_BYTES-1:0][BYTE_W-1:0] byte_group_t;

   // 8-bit brightness of a 12-bit sample: its upper eight bits
   function automatic logic [BYTE_W-1:0] luma8(input logic [PIX_W-1:0] px);
      luma8 = px[PIX_W-1:LUMA_LSB];
   endfunction

   function automatic logic is_paired(input layout_t lay);
      is_paired = (lay == layout_packed12) || (lay == chroma_emulation_layout);
   endfunction

endpackage
`default_nettype wire

// file: mono_pixel_packer_test.sv
// Self-checking bench of the pixel packer against a byte-queue model
`default_nettype none
module mono_pixel_packer_test
   import mono_pixel_packer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, reset_i = 1, pix_valid_i = 0, slow = 0, byte_ready_i, pix_ready_o, byte_valid_o;
   logic frame_active_o, odd_frame_err_o;
   layout_t layout_i = layout_mono8;
   pix_beat_t pix_i = '0;
   byte_beat_t byte_o;
   int n_errors = 0, checked = 0, q[$];
   mono_pixel_packer uut (.clk_i, .reset_i, .layout_i, .pix_valid_i, .pix_i, .pix_ready_o, .byte_valid_o,
      .byte_o, .byte_ready_i, .frame_active_o, .odd_frame_err_o);
   host_image_buffer host (.clk_i(clk_i), .slow_i(slow), .ready_o(byte_ready_i));
   initial forever #20 clk_i = ~clk_i;
   task finish_test();
      if (n_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wait_for(input bit done);
      n_errors += done ? 0 : 1;
      if (!done) finish_test();
   endtask
   // Valid held over back-to-back pixels; cleared once per frame
   task send(input logic [11:0] d, input logic f, input logic l);
      int n;
      pix_valid_i = 1;
      pix_i = '{first: f, last: l, data: d};
      for (n = 0; pix_ready_o !== 1'b1 && n < 200; n++) @(negedge clk_i);
      wait_for(n < 200);
      @(negedge clk_i);
   endtask
   task frame(input layout_t lay, input int n);
      int d, ev, ln, k;
      bit paired;
      paired = (lay == layout_packed12) || (lay == chroma_emulation_layout);
      layout_i = lay;
      for (int i = 0; i < n; i++) begin
         d = i == 0 ? 'hFFF : i == 1 ? 0 : $urandom % 4096;
         ln = (i == n - 1) << 8;
         send(12'(d), i == 0, i == n - 1);
         if (i == 0) layout_i = layout_t'($urandom % 4);
         if (i == 0) check("active", 9'(frame_active_o), 9'(n > 1));
         case (lay)
            layout_mono8: q.push_back((d >> 4) | ln);
            layout_mono16: q = {q, d & 255, (d >> 8) | ln};
            layout_packed12: if (i % 2) q = {q, ev >> 4, ((d & 15) << 4) | (ev & 15), (d >> 4) | ln};
            default: if (i % 2) q = {q, 0, ev >> 4, 0, (d >> 4) | ln};
         endcase
         ev = d;
      end
      pix_valid_i = 0;
      for (k = 0; q.size() > 0 && k < 500; k++) @(negedge clk_i);
      wait_for(k < 500);
      check("odd_err", 9'(odd_frame_err_o), 9'(paired && (n % 2 == 1)));
      check("active_end", 9'(frame_active_o), 9'h000);
   endtask
   always @(posedge clk_i) begin
      if (byte_valid_o === 1'b1 && byte_ready_i === 1'b1) begin
         if (q.size() == 0) check("extra", 9'(q.size()), 9'h001);
         else check("byte", byte_o, 9'(q.pop_front()));
      end
   end
   initial begin
      void'($urandom(32133));
      repeat (3) @(negedge clk_i);
      reset_i = 0;
      check("ready", 9'(pix_ready_o), 9'h001);
      check("bvalid", 9'(byte_valid_o), 9'h000);
      for (int s = 0; s < 2; s++) begin
         for (int l = 0; l < 4; l++) begin
            slow = s;
            frame(layout_t'(l), 6);
         end
      end
      frame(layout_packed12, 5);
      frame(chroma_emulation_layout, 3);
      frame(layout_mono16, 2);
      finish_test();
   end
endmodule
bind mono_pixel_packer mono_pixel_packer_monitor mon (.clk_i, .reset_i, .layout_i, .pix_valid_i, .pix_i,
   .pix_ready_o, .byte_valid_o, .byte_o, .byte_ready_i, .frame_active_o, .odd_frame_err_o);
`default_nettype wire

// file: pair_byte_mapper.sv
// Byte group of one pixel or one pixel pair, per output layout
`default_nettype none
module pair_byte_mapper
   import mono_pixel_packer_pkg::*;
(
   input wire layout_t layout_i,
   input wire logic odd_i,
   input wire logic [PIX_W-1:0] pixel_i,
   input wire logic [PIX_W-1:0] held_i,
   output byte_group_t bytes_o,
   output logic [CNT_W-1:0] count_o
);

   wire logic [BYTE_W-1:0] y_cur;
   wire logic [BYTE_W-1:0] y_held;
   wire byte_group_t grp_mono8;
   wire byte_group_t grp_mono16;
   wire byte_group_t grp_packed12;
   wire byte_group_t grp_chroma;

   assign y_cur = luma8(pixel_i);
   assign y_held = luma8(held_i);

   // Group element 0 goes out first
   assign grp_mono8 = {BYTE_ZERO, BYTE_ZERO, BYTE_ZERO, y_cur};
   assign grp_mono16 = {BYTE_ZERO, BYTE_ZERO, NIBBLE_ZERO, pixel_i[11:8], pixel_i[7:0]};
   assign grp_packed12 = {BYTE_ZERO, pixel_i[11:4], pixel_i[3:0], held_i[3:0], held_i[11:4]};
   assign grp_chroma = {y_cur, CHROMA_ZERO, y_held, CHROMA_ZERO};

   assign bytes_o = (layout_i == layout_mono8) ? grp_mono8 :
                    (layout_i == layout_mono16) ? grp_mono16 :
                    (layout_i == layout_packed12) ? grp_packed12 : grp_chroma;

   // Even pixel of a pair is only held
   assign count_o = (layout_i == layout_mono8) ? CNT_MONO8 :
                    (layout_i == layout_mono16) ? CNT_MONO16 :
                    !odd_i ? CNT_NONE :
                    (layout_i == layout_packed12) ? CNT_PACKED12 : CNT_CHROMA;

endmodule
`default_nettype wire
